// *** verilog/cmw_params.svh ***
/*
  Constants for the mode, window and status front end: register offsets,
  field positions, reset values and error counter and FIFO thresholds.
  Assumes inclusion by bare name from the design files.
*/
`ifndef CMW_PARAMS_SVH
`define CMW_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the plain register port)
// ----------------------------------------------------------------
`define CMW_ADDR_MODE_WIN    8'h00
`define CMW_ADDR_COMM_STAT   8'h01
`define CMW_ADDR_CTRL_STAT   8'h02
`define CMW_ADDR_CTRL        8'h03
`define CMW_ADDR_IRQ_STAT    8'h04
`define CMW_ADDR_IRQ_MASK    8'h05
`define CMW_ADDR_WIN_BASE    8'h10
`define CMW_WIN_SIZE         5'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CMW_ARCH_HI          7
`define CMW_ARCH_LO          6
`define CMW_WM_BIT           5
`define CMW_EWIN_HI          4
`define CMW_CFG_REQ_BIT      7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CMW_MODE_WIN_RESET   8'h10
`define CMW_CTRL_RESET       8'h80
`define CMW_MASK_RESET       8'h00

// ----------------------------------------------------------------
// Thresholds
// ----------------------------------------------------------------
`define CMW_RX_WARN_LOW      8'h5f
`define CMW_RX_WARN_HIGH     8'h7f
`define CMW_TX_WARN_LOW      8'h5f
`define CMW_PASSIVE_LOW      8'h7f
`define CMW_BUS_OFF_LOW      9'h0ff
`define CMW_WM_FREE_HIGH     4'h1
`define CMW_WM_FREE_LOW      4'h4
`define CMW_SHORT_FIFO       4'h4

`endif

// *** verilog/cmw_pkg.sv ***
/*
  Types for the mode, window and status front end.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cmw_pkg;

  // Buffer architecture encodings
  typedef enum logic [1:0] {
    CMW_ARCH_LEGACY = 2'h0,
    CMW_ARCH_ENH_LEGACY = 2'h1,
    CMW_ARCH_FIFO = 2'h2,
    CMW_ARCH_RSVD = 2'h3
  } cmw_arch_type;

  // Register groups reachable through the access window
  typedef enum logic [3:0] {
    CMW_GRP_NONE,
    CMW_GRP_FILT_A,
    CMW_GRP_FILT_B,
    CMW_GRP_MASK_ERR,
    CMW_GRP_TX_DED,
    CMW_GRP_FILT_HI,
    CMW_GRP_RX_IRQ,
    CMW_GRP_RX_BUF,
    CMW_GRP_TXRX_BUF
  } cmw_group_type;

endpackage

// *** verilog/cmw_window_decode.sv ***
/*
  Decodes the five-bit window code into a register group and a
  buffer index inside that group.
  Assumes a code that is already forced to zero in legacy mode.
*/
`timescale 1ns/10ps
`default_nettype none

module cmw_window_decode
  import cmw_pkg::*;
(
  input wire logic [4:0] code_in,
  output var cmw_group_type group_out,
  output logic [2:0] index_out,
  output logic mapped_out
);

  // ----------------------------------------------------------------
  // Code to group mapping
  // ----------------------------------------------------------------
  // Group lookup, reserved codes map nothing
  always_comb
  begin
    group_out = CMW_GRP_NONE;
    index_out = 3'h0;
    unique case (code_in)
      5'h00: group_out = CMW_GRP_FILT_A;
      5'h01: group_out = CMW_GRP_FILT_B;
      5'h02: group_out = CMW_GRP_MASK_ERR;
      5'h03, 5'h04, 5'h05:
      begin
        group_out = CMW_GRP_TX_DED;
        index_out = 3'(code_in - 5'h03);
      end
      5'h06, 5'h07, 5'h08, 5'h09:
      begin
        group_out = CMW_GRP_FILT_HI;
        index_out = 3'(code_in - 5'h06);
      end
      5'h0f: group_out = CMW_GRP_RX_IRQ;
      5'h10, 5'h11:
      begin
        group_out = CMW_GRP_RX_BUF;
        index_out = 3'(code_in - 5'h10);
      end
      5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17:
      begin
        group_out = CMW_GRP_TXRX_BUF;
        index_out = 3'(code_in - 5'h12);
      end
      default: group_out = CMW_GRP_NONE;
    endcase
  end

  assign mapped_out = (group_out != CMW_GRP_NONE);

endmodule
`default_nettype wire

// *** verilog/cmw_mode_window_status.sv ***
/*
  Mode select, FIFO watermark, access window and communication status
  front end of an enhanced CAN controller, on a plain register port.
  Assumes the protocol engine supplies error counts, FIFO state,
  overflow events and interrupt codes on the host clock.
*/
// Functional notes
// - Two-bit field selects buffer architecture
// - Mode changes only in configuration mode
// - Watermark picks one or four free buffers
// - Watermark only acts in FIFO mode
// - Short FIFO forces watermark bit set
// - Window field selects banked register group
// - Codes zero, one, six-nine: filters; two: masks, errors
// - Codes three to five: transmit buffers
// - Code 0F receive irq, 10-11 receive buffers
// - Codes 12-17 configurable buffers, others reserved
// - Legacy mode: window field reads zero
// - Controller status register is read-only
// - Legacy overflow flags, clearable, reset zero
// - Receive warning between 96 and 127
// - Extended interrupt code matches window coding
`include "cmw_params.svh"
`timescale 1ns/10ps
`default_nettype none

module cmw_mode_window_status
  import cmw_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic RESET_N_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [2:0] OP_MODE_IN,
  input wire logic [4:0] EXT_IRQ_CODE_IN,
  input wire logic [7:0] RX_ERR_COUNT_IN,
  input wire logic [8:0] TX_ERR_COUNT_IN,
  input wire logic [3:0] FIFO_LENGTH_IN,
  input wire logic [3:0] FIFO_FREE_IN,
  input wire logic FIFO_NOT_EMPTY_IN,
  input wire logic RX_BUF0_OVF_IN,
  input wire logic RX_BUF1_OVF_IN,
  input wire logic [7:0] WIN_RDATA_IN,
  output logic [7:0] RDATA_OUT,
  output logic [1:0] BUFFER_ARCH_OUT,
  output logic [4:0] WINDOW_GROUP_OUT,
  output logic [2:0] WINDOW_INDEX_OUT,
  output logic WIN_WR_OUT,
  output logic [3:0] WIN_OFFSET_OUT,
  output logic [7:0] WIN_WDATA_OUT,
  output logic CONFIG_REQ_OUT,
  output logic IRQ_OUT
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] mode_win_reg;
  logic [7:0] mode_win_next;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [1:0] ovf_reg;
  logic [1:0] ovf_next;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_stat_next;
  logic [2:0] irq_mask_reg;
  logic [2:0] irq_mask_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic fifo_level_reg;
  logic irq_reg;
  logic win_wr_reg;
  logic [3:0] win_off_reg;
  logic [7:0] win_wdata_reg;
  logic [4:0] group_reg;
  logic [2:0] index_reg;
  logic [2:0] op_mode_meta_reg;
  logic [2:0] op_mode_sync_reg;

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  // Address decode
  wire sel_mode_win = (ADDR_IN == `CMW_ADDR_MODE_WIN);
  wire sel_comm = (ADDR_IN == `CMW_ADDR_COMM_STAT);
  wire sel_ctrl_stat = (ADDR_IN == `CMW_ADDR_CTRL_STAT);
  wire sel_ctrl = (ADDR_IN == `CMW_ADDR_CTRL);
  wire sel_istat = (ADDR_IN == `CMW_ADDR_IRQ_STAT);
  wire sel_imask = (ADDR_IN == `CMW_ADDR_IRQ_MASK);
  wire sel_win = (ADDR_IN[7:4] == 4'(`CMW_ADDR_WIN_BASE >> 4));

  // Mode and field views
  cmw_arch_type arch;
  assign arch = cmw_arch_type'(mode_win_reg[`CMW_ARCH_HI:`CMW_ARCH_LO]);
  wire is_legacy = (arch == CMW_ARCH_LEGACY);
  wire is_fifo = (arch == CMW_ARCH_FIFO);
  wire in_config = (op_mode_sync_reg == 3'h4);
  wire short_fifo = (FIFO_LENGTH_IN <= `CMW_SHORT_FIFO);
  wire wm_eff = mode_win_reg[`CMW_WM_BIT] | short_fifo;
  wire [4:0] ewin_eff = is_legacy ? 5'h00 : mode_win_reg[`CMW_EWIN_HI:0];
  wire [4:0] ext_code = EXT_IRQ_CODE_IN;

  // Window decode
  cmw_group_type win_group;
  logic [2:0] win_index;
  logic win_mapped;
  cmw_window_decode u_decode (
    .code_in(ewin_eff),
    .group_out(win_group),
    .index_out(win_index),
    .mapped_out(win_mapped)
  );

  // Error states
  wire rx_warn = (RX_ERR_COUNT_IN > `CMW_RX_WARN_LOW) &&
                 (RX_ERR_COUNT_IN <= `CMW_RX_WARN_HIGH);
  wire tx_warn = (TX_ERR_COUNT_IN > {1'b0, `CMW_TX_WARN_LOW}) &&
                 (TX_ERR_COUNT_IN <= {1'b0, `CMW_PASSIVE_LOW});
  wire rx_pass = (RX_ERR_COUNT_IN > `CMW_PASSIVE_LOW);
  wire tx_pass = (TX_ERR_COUNT_IN > {1'b0, `CMW_PASSIVE_LOW});
  wire tx_off = (TX_ERR_COUNT_IN > `CMW_BUS_OFF_LOW);

  // FIFO watermark level and its rising edge
  wire [3:0] wm_thresh = wm_eff ? `CMW_WM_FREE_HIGH : `CMW_WM_FREE_LOW;
  wire fifo_level = is_fifo && (FIFO_FREE_IN <= wm_thresh);
  wire fifo_event = fifo_level & ~fifo_level_reg;

  // Communication status assembly
  wire bit7 = is_legacy ? ovf_reg[0] :
              (is_fifo ? FIFO_NOT_EMPTY_IN : 1'b0);
  wire bit6 = ovf_reg[1];
  wire [7:0] comm_stat = {bit7, bit6, tx_off, tx_pass, rx_pass, tx_warn, rx_warn,
                          rx_warn | tx_warn};

  // Controller status, read-only view of mode and code
  wire [7:0] ctrl_stat = is_legacy ? {op_mode_sync_reg, 1'b0, ext_code[3:1], 1'b0} :
                         {op_mode_sync_reg, ext_code};

  // Read mux
  wire [7:0] mode_win_view = {mode_win_reg[7:6], wm_eff, ewin_eff};
  wire [7:0] win_rd = win_mapped ? WIN_RDATA_IN : 8'h00;
  assign rdata_next = !RD_IN ? 8'h00 :
                      sel_mode_win ? mode_win_view :
                      sel_comm ? comm_stat :
                      sel_ctrl_stat ? ctrl_stat :
                      sel_ctrl ? ctrl_reg :
                      sel_istat ? {5'h00, irq_stat_reg} :
                      sel_imask ? {5'h00, irq_mask_reg} :
                      sel_win ? win_rd : 8'h00;

  // Mode and window register update
  wire wr_mw = WR_IN && sel_mode_win;
  wire [1:0] arch_new = in_config ? WDATA_IN[7:6] : mode_win_reg[7:6];
  assign mode_win_next = wr_mw ? {arch_new, WDATA_IN[5:0]} : mode_win_reg;
  assign ctrl_next = (WR_IN && sel_ctrl) ? WDATA_IN : ctrl_reg;

  // Overflow clear and set; flag 0 shows as status bit 7 in legacy mode only, flag 1 as bit 6
  wire [1:0] ovf_clr = (WR_IN && sel_comm) ? {WDATA_IN[6], WDATA_IN[7]} : 2'h0;
  wire [1:0] ovf_set = {RX_BUF1_OVF_IN, RX_BUF0_OVF_IN};

  // Interrupt events: bit0 overflow, bit1 fifo watermark, bit2 warning
  logic warn_reg;
  wire warn_event = (rx_warn | tx_warn) & ~warn_reg;
  wire [2:0] ev = {warn_event, fifo_event, |ovf_set};
  wire [2:0] istat_clr = (WR_IN && sel_istat) ? WDATA_IN[2:0] : 3'h0;
  assign irq_mask_next = (WR_IN && sel_imask) ? WDATA_IN[2:0] : irq_mask_reg;

  // ----------------------------------------------------------------
  // Sticky flags
  // ----------------------------------------------------------------
  // Overflow flags, one cell per buffer; a set in the clearing cycle wins
  genvar ovf_bit;
  generate
    for (ovf_bit = 0; ovf_bit < 2; ovf_bit++)
    begin : g_ovf
      assign ovf_next[ovf_bit] = (ovf_reg[ovf_bit] & ~ovf_clr[ovf_bit]) |
                                 ovf_set[ovf_bit];
    end
  endgenerate

  // Interrupt status, one cell per event; a set in the clearing cycle wins
  genvar ist_bit;
  generate
    for (ist_bit = 0; ist_bit < 3; ist_bit++)
    begin : g_istat
      assign irq_stat_next[ist_bit] = (irq_stat_reg[ist_bit] & ~istat_clr[ist_bit]) |
                                      ev[ist_bit];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Operation mode synchroniser
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      op_mode_meta_reg <= 3'h0;
      op_mode_sync_reg <= 3'h0;
    end
    else
    begin
      op_mode_meta_reg <= OP_MODE_IN;
      op_mode_sync_reg <= op_mode_meta_reg;
    end
  end

  // Mode, window and control registers
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      mode_win_reg <= `CMW_MODE_WIN_RESET;
      ctrl_reg <= `CMW_CTRL_RESET;
    end
    else
    begin
      mode_win_reg <= mode_win_next;
      ctrl_reg <= ctrl_next;
    end
  end

  // Sticky flags and interrupt mask
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      ovf_reg <= 2'h0;
      irq_stat_reg <= 3'h0;
      irq_mask_reg <= 3'(`CMW_MASK_RESET);
    end
    else
    begin
      ovf_reg <= ovf_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // Level history for the rising-edge events
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      fifo_level_reg <= 1'b0;
      warn_reg <= 1'b0;
    end
    else
    begin
      fifo_level_reg <= fifo_level;
      warn_reg <= rx_warn | tx_warn;
    end
  end

  // Read data and interrupt output
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      rdata_reg <= 8'h00;
      irq_reg <= 1'b0;
    end
    else
    begin
      rdata_reg <= rdata_next;
      irq_reg <= |(irq_stat_next & irq_mask_next);
    end
  end

  // Window access strobes toward the banked registers
  always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      win_wr_reg <= 1'b0;
      win_off_reg <= 4'h0;
      win_wdata_reg <= 8'h00;
      group_reg <= 5'h00;
      index_reg <= 3'h0;
    end
    else
    begin
      win_wr_reg <= WR_IN && sel_win && win_mapped;
      win_off_reg <= ADDR_IN[3:0];
      win_wdata_reg <= WDATA_IN;
      group_reg <= 5'(win_group);
      index_reg <= win_index;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign RDATA_OUT = rdata_reg;
  assign BUFFER_ARCH_OUT = mode_win_reg[7:6];
  assign WINDOW_GROUP_OUT = group_reg;
  assign WINDOW_INDEX_OUT = index_reg;
  assign WIN_WR_OUT = win_wr_reg;
  assign WIN_OFFSET_OUT = win_off_reg;
  assign WIN_WDATA_OUT = win_wdata_reg;
  assign CONFIG_REQ_OUT = ctrl_reg[`CMW_CFG_REQ_BIT];
  assign IRQ_OUT = irq_reg;

endmodule
`default_nettype wire

// *** tb/cmw_mws_chk.sv ***
/*
  Checker for the mode, window and status front end.
  Assumes a bind onto the top module ports, one clock domain.
*/
`timescale 1ns/10ps
`default_nettype none

module cmw_mws_chk (
  input wire logic CLOCK_IN,
  input wire logic RESET_N_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic [1:0] BUFFER_ARCH_OUT,
  input wire logic [4:0] WINDOW_GROUP_OUT,
  input wire logic WIN_WR_OUT,
  input wire logic [3:0] WIN_OFFSET_OUT,
  input wire logic [7:0] WIN_WDATA_OUT,
  input wire logic CONFIG_REQ_OUT,
  input wire logic IRQ_OUT
);
  // ------------------------------
  // Port relations
  // ------------------------------
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESET_N_IN);

  rdata_idle_a: assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00)
    else $error("read data without a read");
  unmapped_rd_a: assert property ($past(RD_IN) && $past(ADDR_IN) == 8'h06 |-> RDATA_OUT == 8'h00)
    else $error("unmapped read not zero");
  win_wr_src_a: assert property (WIN_WR_OUT |-> $past(WR_IN) && ($past(ADDR_IN) & 8'hf0) == 8'h10)
    else $error("window write without cause");
  win_data_a: assert property (WIN_WR_OUT |-> {4'h1, WIN_OFFSET_OUT} == $past(ADDR_IN)
    && WIN_WDATA_OUT == $past(WDATA_IN))
    else $error("window write address or data wrong");
  arch_hold_a: assert property ($changed(BUFFER_ARCH_OUT) |-> $past(WR_IN) && $past(ADDR_IN) == 8'h00)
    else $error("mode changed without a write");
  cfg_hold_a: assert property ($changed(CONFIG_REQ_OUT) |-> $past(WR_IN) && $past(ADDR_IN) == 8'h03)
    else $error("config request changed without a write");
  mask_off_a: assert property (WR_IN && ADDR_IN == 8'h05 && WDATA_IN == 8'h00 |=> !IRQ_OUT)
    else $error("interrupt with all masked");
  legacy_grp_a: assert property ((BUFFER_ARCH_OUT == 2'h0) [*3] |-> WINDOW_GROUP_OUT == 5'h01)
    else $error("legacy window not group one");
endmodule

`default_nettype wire

// *** tb/cmw_mode_window_status_tb.sv ***
/*
  Self-checking bench for the mode, window and status front end.
  Assumes design files and checker compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none

module cmw_mode_window_status_tb;
  logic clk = 1'b0, rst_n = 1'b0, wstb = 1'b0, rstb = 1'b0, ne = 1'b0, ov0 = 1'b0, ov1 = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rxc = 8'h00, rdata, wwd;
  logic [8:0] txc = 9'h000;
  logic [4:0] code = 5'h00, grp, g;
  logic [3:0] flen = 4'h8, free = 4'h8, woff;
  logic [2:0] opm = 3'h0, idx;
  logic [1:0] arch;
  logic wwr, cfg, irq;
  int bad_count = 0, compares = 0;
  logic [7:0] rxv [6] = '{8'h5f, 8'h60, 8'h7f, 8'h80, 8'hff, 8'h00};
  logic [8:0] txv [6] = '{9'h05f, 9'h060, 9'h07f, 9'h080, 9'h0ff, 9'h100};

  cmw_mode_window_status u_dut (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .ADDR_IN(addr),
    .WDATA_IN(wdata), .WR_IN(wstb), .RD_IN(rstb), .OP_MODE_IN(opm), .EXT_IRQ_CODE_IN(code),
    .RX_ERR_COUNT_IN(rxc), .TX_ERR_COUNT_IN(txc), .FIFO_LENGTH_IN(flen), .FIFO_FREE_IN(free),
    .FIFO_NOT_EMPTY_IN(ne), .RX_BUF0_OVF_IN(ov0), .RX_BUF1_OVF_IN(ov1), .WIN_RDATA_IN(8'h5a),
    .RDATA_OUT(rdata), .BUFFER_ARCH_OUT(arch), .WINDOW_GROUP_OUT(grp), .WINDOW_INDEX_OUT(idx),
    .WIN_WR_OUT(wwr), .WIN_OFFSET_OUT(woff), .WIN_WDATA_OUT(wwd), .CONFIG_REQ_OUT(cfg),
    .IRQ_OUT(irq));

  // Free-running clock
  initial
  begin
    forever #5 clk = ~clk;
  end

  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wstb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wstb <= 1'b0;
    #1;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rstb <= 1'b1;
    addr <= a;
    @(posedge clk);
    rstb <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // Free count step, then clear the watermark flag
  task automatic wm_try(input logic [3:0] f, input logic e);
    free <= f;
    cyc(4);
    chk(irq, e);
    free <= 4'h8;
    cyc(2);
    reg_wr(8'h04, 8'h02);
    cyc(1);
    chk(irq, 1'b0);
  endtask

  function automatic logic [7:0] stat_of(input logic [7:0] r, input logic [8:0] t);
    logic rw, tw;
    rw = r > 8'h5f && r <= 8'h7f;
    tw = t > 9'h05f && t <= 9'h07f;
    return {2'h0, t > 9'h0ff, t > 9'h07f, r > 8'h7f, tw, rw, rw | tw};
  endfunction

  task automatic end_sim;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  // Reset values, control request bit, legacy status code
  task automatic t_reset_values;
    chk(cfg, 1'b1);
    reg_rd(8'h00, 8'h00);
    reg_rd(8'h03, 8'h80);
    reg_rd(8'h06, 8'h00);
    reg_wr(8'h03, 8'h00);
    chk(cfg, 1'b0);
    reg_wr(8'h03, 8'h80);
    chk(cfg, 1'b1);
    code <= 5'h1c;
    reg_rd(8'h02, 8'h0c);
    code <= 5'h00;
  endtask

  // Error counter thresholds in the status register
  task automatic t_error_states;
    for (int i = 0; i < 6; i++)
    begin
      rxc <= rxv[i];
      txc <= txv[i];
      cyc(2);
      reg_rd(8'h01, stat_of(rxv[i], txv[i]));
    end
    rxc <= 8'h00;
    txc <= 9'h000;
  endtask

  // Legacy overflow flags and their write-one clear
  task automatic t_overflow;
    ov0 <= 1'b1;
    ov1 <= 1'b1;
    cyc(1);
    ov0 <= 1'b0;
    ov1 <= 1'b0;
    reg_rd(8'h01, 8'hc0);
    reg_wr(8'h01, 8'h7f);
    reg_rd(8'h01, 8'h80);
    reg_wr(8'h01, 8'h80);
    reg_rd(8'h01, 8'h00);
  endtask

  // Mode field locked outside configuration, then each mode
  task automatic t_mode_lock;
    reg_wr(8'h00, 8'h43);
    reg_rd(8'h00, 8'h00);
    opm <= 3'h4;
    cyc(3);
    for (int m = 0; m < 4; m++)
    begin
      reg_wr(8'h00, {m[1:0], 6'h03});
      reg_rd(8'h00, m == 0 ? 8'h00 : {m[1:0], 6'h03});
      chk(arch, m[1:0]);
    end
  endtask

  // Every window code: group, index (not checked for codes 6-9), window write and read
  task automatic t_window_map;
    for (int c = 0; c < 32; c++)
    begin
      reg_wr(8'h00, {3'h2, c[4:0]});
      cyc(1);
      g = c < 3 ? c[4:0] + 5'h01 : c < 6 ? 5'h04 : c < 10 ? 5'h05 : c == 15 ? 5'h06
        : c < 16 ? 5'h00 : c < 18 ? 5'h07 : c < 24 ? 5'h08 : 5'h00;
      chk(grp, g);
      if (g == 5'h04 || g == 5'h07 || g == 5'h08)
        chk(idx, c[2:0] - (g == 5'h04 ? 3'h3 : g == 5'h07 ? 3'h0 : 3'h2));
      reg_wr(8'h13, 8'ha5);
      chk(wwr, g != 5'h00);
      reg_rd(8'h1c, g != 5'h00 ? 8'h5a : 8'h00);
    end
  endtask

  // Read-only controller status and code copy into the window
  task automatic t_ctrl_status;
    code <= 5'h12;
    cyc(2);
    reg_rd(8'h02, 8'h92);
    reg_wr(8'h02, 8'h00);
    reg_rd(8'h02, 8'h92);
    reg_wr(8'h00, 8'h52);
    cyc(1);
    chk(grp, 5'h08);
  endtask

  // Watermark thresholds, mode gating and short FIFO forcing
  task automatic t_watermark;
    reg_wr(8'h05, 8'h02);
    reg_wr(8'h00, 8'ha0);
    wm_try(4'h2, 1'b0);
    wm_try(4'h1, 1'b1);
    reg_wr(8'h00, 8'h80);
    wm_try(4'h5, 1'b0);
    wm_try(4'h4, 1'b1);
    reg_wr(8'h00, 8'h60);
    wm_try(4'h0, 1'b0);
    flen <= 4'h4;
    reg_wr(8'h00, 8'h80);
    reg_rd(8'h00, 8'ha0);
  endtask

  // FIFO not-empty flag in status bit 7
  task automatic t_not_empty;
    ne <= 1'b1;
    reg_rd(8'h01, 8'h80);
    ne <= 1'b0;
    reg_rd(8'h01, 8'h00);
    reg_wr(8'h05, 8'h00);
  endtask

  // Reset, then every scenario in turn
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_values();
    t_error_states();
    t_overflow();
    t_mode_lock();
    t_window_map();
    t_ctrl_status();
    t_watermark();
    t_not_empty();
    end_sim();
  end
endmodule

bind cmw_mode_window_status cmw_mws_chk u_chk (.CLOCK_IN, .RESET_N_IN, .ADDR_IN, .WDATA_IN,
  .WR_IN, .RD_IN, .RDATA_OUT, .BUFFER_ARCH_OUT, .WINDOW_GROUP_OUT, .WIN_WR_OUT,
  .WIN_OFFSET_OUT, .WIN_WDATA_OUT, .CONFIG_REQ_OUT, .IRQ_OUT);

`default_nettype wire
